// ===== hw/irc_pkg.sv
// Package: constants shared by the initial reset controller files
package irc_pkg;

    // ------------------------------------------------------------------
    // Slow oscillator and release divider
    // ------------------------------------------------------------------
    localparam int OSC_HZ            = 32768;
    localparam int TICK_HZ           = 2;
    localparam int DIV_W_DEF         = $clog2(OSC_HZ / TICK_HZ);
    localparam int RELEASE_MAX_MS    = 250;
    localparam int RELEASE_MAX_TICKS = RELEASE_MAX_MS * OSC_HZ / 1000;

    // ------------------------------------------------------------------
    // Times kept by the board (not enforced here)
    // ------------------------------------------------------------------
    localparam int PIN_MIN_US        = 100;
    localparam int POWERUP_MIN_US    = 2000;

    // ------------------------------------------------------------------
    // Key combination filter
    // ------------------------------------------------------------------
    localparam int NOISE_MIN_US      = 1500;
    localparam int NOISE_TICKS_DEF   =
        (NOISE_MIN_US * OSC_HZ + 999999) / 1000000;
    localparam int AUTH_MIN_MS       = 1000;
    localparam int AUTH_MAX_MS       = 2000;
    localparam int AUTH_MS           = 1500;
    localparam int AUTH_TICKS_DEF    = AUTH_MS * OSC_HZ / 1000;
    localparam int CNT_W             = 17;
    localparam int KEY_OPT_OFF       = 1;
    localparam int KEY_OPT_K4        = 2;
    localparam int KEY_OPT_K3        = 3;
    localparam int KEY_OPT_K2        = 4;

    // ------------------------------------------------------------------
    // Core and port state at reset
    // ------------------------------------------------------------------
    localparam logic [15:0] PC_RESET    = 16'h0110;
    localparam int          WSP_W       = 10;
    localparam int          NSP_W       = 8;
    localparam int          PREFIX_W    = 8;
    localparam int          R_PORTS     = 12;
    localparam int          P_PORTS     = 16;
    localparam logic [11:0] R_DATA_RST  = 12'hfff;
    localparam logic [11:0] R_FUNC_RST  = 12'h000;
    localparam logic [15:0] P_DIR_RST   = 16'h0000;
    localparam logic [15:0] P_DATA_RST  = 16'h0000;
    localparam logic [15:0] P_FUNC_RST  = 16'h0000;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS  = 8'h00;
    localparam logic [7:0] OFS_WSP     = 8'h04;
    localparam logic [7:0] OFS_NSP     = 8'h08;
    localparam logic [7:0] OFS_PREFIX  = 8'h0c;
    localparam logic [7:0] OFS_FLAGS   = 8'h10;
    localparam logic [7:0] OFS_R_DATA  = 8'h14;
    localparam logic [7:0] OFS_R_FUNC  = 8'h18;
    localparam logic [7:0] OFS_P_DIR   = 8'h1c;
    localparam logic [7:0] OFS_P_DATA  = 8'h20;
    localparam logic [7:0] OFS_P_FUNC  = 8'h24;
    localparam logic [7:0] OFS_P_IN    = 8'h28;

    // ------------------------------------------------------------------
    // Status and flag bit positions
    // ------------------------------------------------------------------
    localparam int ST_RESET    = 0;
    localparam int ST_KEY      = 1;
    localparam int ST_INT_EN   = 2;
    localparam int ST_EXT      = 3;
    localparam int ST_PIN      = 4;
    localparam int ST_TICK     = 5;
    localparam int FL_INT      = 0;

endpackage

// ===== hw/irc_key_filter.sv
// Key combination detector with noise filter and time authorize stage
`timescale 1ns/1ns
module irc_key_filter
    import irc_pkg::*;
#(
    parameter int KEY_OPTION  = KEY_OPT_K4,
    parameter bit TIME_AUTH   = 1'b0,
    parameter int NOISE_TICKS = NOISE_TICKS_DEF,
    parameter int AUTH_TICKS  = AUTH_TICKS_DEF
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       osc_tick,
    input  wire logic [3:0] key_level,
    output logic            key_req
);

    localparam int NEED = TIME_AUTH ? AUTH_TICKS : NOISE_TICKS;
    localparam logic [CNT_W-1:0] NEED_CNT = NEED[CNT_W-1:0];

    // ------------------------------------------------------------------
    // Build-time checks
    // ------------------------------------------------------------------
    if (KEY_OPTION < KEY_OPT_OFF || KEY_OPTION > KEY_OPT_K2)
        $error("key option must be 1 to 4");
    if (NEED < 1 || NEED >= (1 << CNT_W) || AUTH_TICKS < NOISE_TICKS)
        $error("filter tick counts out of range");

    function automatic logic [3:0] key_select(input int opt);
        case (opt)
            KEY_OPT_K4: return 4'hf;
            KEY_OPT_K3: return 4'h7;
            KEY_OPT_K2: return 4'h3;
            default:    return 4'h0;
        endcase
    endfunction

    localparam logic [3:0] KEY_SEL = key_select(KEY_OPTION);

    logic             combo_low;
    logic [CNT_W-1:0] low_ticks;
    logic [CNT_W-1:0] next_low_ticks;
    logic             next_key_req;

    // Unselected keys are ignored; option 1 never matches
    assign combo_low = (KEY_SEL != 4'h0) &&
                       ((key_level & KEY_SEL) == 4'h0);

    // Counts only on oscillator ticks: dead until oscillation starts
    always_comb begin
        next_low_ticks = '0;
        if (combo_low) begin
            if (low_ticks == NEED_CNT) begin
                next_low_ticks = low_ticks;
            end else begin
                next_low_ticks = low_ticks +
                    {{(CNT_W-1){1'b0}}, osc_tick};
            end
        end
        next_key_req = combo_low && (next_low_ticks == NEED_CNT);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            low_ticks <= '0;
            key_req   <= 1'b0;
        end else begin
            low_ticks <= next_low_ticks;
            key_req   <= next_key_req;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_key_min_time: assert property (
        key_req |-> low_ticks == NEED_CNT)
        else $error("key request before filter time");
    chk_key_release: assert property (
        !combo_low |=> !key_req)
        else $error("key request without simultaneous low");

endmodule // irc_key_filter

// ===== hw/irc_controller.sv
// Initial reset controller: latch, release divider, core and port state
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ns
module irc_controller
    import irc_pkg::*;
#(
    parameter int          KEY_OPTION  = KEY_OPT_K4,
    parameter bit          TIME_AUTH   = 1'b0,
    parameter int          NOISE_TICKS = NOISE_TICKS_DEF,
    parameter int          AUTH_TICKS  = AUTH_TICKS_DEF,
    parameter int          DIV_W       = DIV_W_DEF,
    parameter logic [15:0] P_PULLUP    = 16'hffff
) (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire logic [7:0]          paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                reset_pin_n,
    input  wire logic                slow_oscillator,
    input  wire logic [3:0]          key_input_ports,
    input  wire logic                cpu_step,
    output logic                     init_reset,
    output logic      [15:0]         pc_start,
    output logic                     interrupt_flag,
    output logic                     extension_flag,
    output logic                     int_enable,
    output logic      [WSP_W-1:0]    word_stack_pointer,
    output logic      [NSP_W-1:0]    nibble_stack_pointer,
    output logic      [R_PORTS-1:0]  r_port_out,
    output logic      [R_PORTS-1:0]  r_port_func,
    input  wire logic [P_PORTS-1:0]  p_port_in,
    output logic      [P_PORTS-1:0]  p_port_out,
    output logic      [P_PORTS-1:0]  p_port_oe_n,
    output logic      [P_PORTS-1:0]  p_pullup_en,
    output logic      [P_PORTS-1:0]  p_port_func
);

    if (DIV_W < 2 || DIV_W > 20)
        $error("divider width out of range");

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0]         pin_meta;
    logic [2:0]         osc_meta;
    logic [3:0]         key_meta;
    logic [3:0]         key_s;
    logic [P_PORTS-1:0] pin_in_meta;
    logic [P_PORTS-1:0] p_in_s;
    logic               pin_s;
    logic               osc_rise;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pin_meta    <= 2'h0;
            osc_meta    <= 3'h0;
            key_meta    <= 4'hf;
            key_s       <= 4'hf;
            pin_in_meta <= '1;
            p_in_s      <= '1;
        end else begin
            pin_meta    <= {pin_meta[0], reset_pin_n};
            osc_meta    <= {osc_meta[1:0], slow_oscillator};
            key_meta    <= key_input_ports;
            key_s       <= key_meta;
            pin_in_meta <= p_port_in;
            p_in_s      <= pin_in_meta;
        end
    end

    assign pin_s    = pin_meta[1];
    assign osc_rise = osc_meta[1] & ~osc_meta[2];

    // ------------------------------------------------------------------
    // Key combination path
    // ------------------------------------------------------------------
    logic key_req;

    irc_key_filter #(
        .KEY_OPTION  (KEY_OPTION),
        .TIME_AUTH   (TIME_AUTH),
        .NOISE_TICKS (NOISE_TICKS),
        .AUTH_TICKS  (AUTH_TICKS)
    ) u_key_filter (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .osc_tick  (osc_rise),
        .key_level (key_s),
        .key_req   (key_req)
    );

    // ------------------------------------------------------------------
    // Release divider and reset latch
    // ------------------------------------------------------------------
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] next_div;
    logic             tick_high;
    logic             latch_set;
    logic             latch_clr;
    logic             next_init_reset;

    assign tick_high = div[DIV_W-1];
    assign latch_set = ~pin_s | key_req;
    assign latch_clr = tick_high & pin_s;

    // Divider ignores the latch so the tick phase never stalls in reset
    always_comb begin
        next_div = div + {{(DIV_W-1){1'b0}}, osc_rise};
        // Set dominates: a live pin or key request holds reset
        next_init_reset = latch_set | (init_reset & ~latch_clr);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            div        <= '0;
            init_reset <= 1'b1;
        end else begin
            div        <= next_div;
            init_reset <= next_init_reset;
        end
    end

    // ------------------------------------------------------------------
    // Register file, core state and port state
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    logic               wr_acc;
    logic               mapped;
    logic               wsp_seen;
    logic               nsp_seen;
    logic [PREFIX_W-1:0] prefix;
    logic [R_PORTS-1:0] r_data;
    logic [P_PORTS-1:0] p_dir;
    logic [31:0]        next_prdata;
    logic [WSP_W-1:0]   next_wsp;
    logic [NSP_W-1:0]   next_nsp;
    logic [PREFIX_W-1:0] next_prefix;
    logic               next_wsp_seen;
    logic               next_nsp_seen;
    logic               next_int_flag;
    logic               next_ext_flag;
    logic [R_PORTS-1:0] next_r_data;
    logic [R_PORTS-1:0] next_r_func;
    logic [P_PORTS-1:0] next_p_dir;
    logic [P_PORTS-1:0] next_p_data;
    logic [P_PORTS-1:0] next_p_func;

    assign wr_acc  = psel & penable & pwrite & ~init_reset;
    assign mapped  = paddr <= OFS_P_IN && paddr[1:0] == 2'h0;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always_comb begin
        next_wsp      = word_stack_pointer;
        next_nsp      = nibble_stack_pointer;
        next_prefix   = prefix;
        next_wsp_seen = wsp_seen;
        next_nsp_seen = nsp_seen;
        next_int_flag = interrupt_flag;
        next_ext_flag = extension_flag;
        next_r_data   = r_data;
        next_r_func   = r_port_func;
        next_p_dir    = p_dir;
        next_p_data   = p_port_out;
        next_p_func   = p_port_func;
        if (cpu_step) begin
            next_ext_flag = 1'b0;
        end
        if (wr_acc) begin
            if (hit(paddr, OFS_WSP)) begin
                next_wsp      = pwdata[WSP_W-1:0];
                next_wsp_seen = 1'b1;
                // Rewriting one pointer re-arms the mask until the pair
                next_nsp_seen = nsp_seen & ~wsp_seen;
            end
            if (hit(paddr, OFS_NSP)) begin
                next_nsp      = pwdata[NSP_W-1:0];
                next_nsp_seen = 1'b1;
                next_wsp_seen = wsp_seen & ~nsp_seen;
            end
            if (hit(paddr, OFS_PREFIX)) begin
                next_prefix   = pwdata[PREFIX_W-1:0];
                next_ext_flag = 1'b1;
            end
            if (hit(paddr, OFS_FLAGS)) begin
                next_int_flag = pwdata[FL_INT];
            end
            if (hit(paddr, OFS_R_DATA)) begin
                next_r_data = pwdata[R_PORTS-1:0];
            end
            if (hit(paddr, OFS_R_FUNC)) begin
                next_r_func = pwdata[R_PORTS-1:0];
            end
            if (hit(paddr, OFS_P_DIR)) begin
                next_p_dir = pwdata[P_PORTS-1:0];
            end
            if (hit(paddr, OFS_P_DATA)) begin
                next_p_data = pwdata[P_PORTS-1:0];
            end
            if (hit(paddr, OFS_P_FUNC)) begin
                next_p_func = pwdata[P_PORTS-1:0];
            end
        end
        if (init_reset) begin
            next_wsp_seen = 1'b0;
            next_nsp_seen = 1'b0;
            next_int_flag = 1'b0;
            next_ext_flag = 1'b0;
            next_r_data   = R_DATA_RST;
            next_r_func   = R_FUNC_RST;
            next_p_dir    = P_DIR_RST;
            next_p_data   = P_DATA_RST;
            next_p_func   = P_FUNC_RST;
        end
    end

    // Read data is latched in the setup phase, zero wait states after
    always_comb begin
        next_prdata = prdata;
        if (psel && !penable) begin
            next_prdata = 32'h0000_0000;
            case (paddr)
                OFS_STATUS: begin
                    next_prdata[ST_RESET]  = init_reset;
                    next_prdata[ST_KEY]    = key_req;
                    next_prdata[ST_INT_EN] = int_enable;
                    next_prdata[ST_EXT]    = extension_flag;
                    next_prdata[ST_PIN]    = pin_s;
                    next_prdata[ST_TICK]   = tick_high;
                end
                OFS_WSP:    next_prdata[WSP_W-1:0]    = word_stack_pointer;
                OFS_NSP:    next_prdata[NSP_W-1:0]    = nibble_stack_pointer;
                OFS_PREFIX: next_prdata[PREFIX_W-1:0] = prefix;
                OFS_FLAGS:  next_prdata[FL_INT]       = interrupt_flag;
                OFS_R_DATA: next_prdata[R_PORTS-1:0]  = r_data;
                OFS_R_FUNC: next_prdata[R_PORTS-1:0]  = r_port_func;
                OFS_P_DIR:  next_prdata[P_PORTS-1:0]  = p_dir;
                OFS_P_DATA: next_prdata[P_PORTS-1:0]  = p_port_out;
                OFS_P_FUNC: next_prdata[P_PORTS-1:0]  = p_port_func;
                OFS_P_IN:   next_prdata[P_PORTS-1:0]  = p_in_s;
                default:    next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata               <= 32'h0000_0000;
            pc_start             <= PC_RESET;
            word_stack_pointer   <= '0;
            nibble_stack_pointer <= '0;
            prefix               <= '0;
            wsp_seen             <= 1'b0;
            nsp_seen             <= 1'b0;
            interrupt_flag       <= 1'b0;
            extension_flag       <= 1'b0;
            r_data               <= R_DATA_RST;
            r_port_func          <= R_FUNC_RST;
            p_dir                <= P_DIR_RST;
            p_port_out           <= P_DATA_RST;
            p_port_func          <= P_FUNC_RST;
        end else begin
            prdata               <= next_prdata;
            pc_start             <= PC_RESET;
            word_stack_pointer   <= next_wsp;
            nibble_stack_pointer <= next_nsp;
            prefix               <= next_prefix;
            wsp_seen             <= next_wsp_seen;
            nsp_seen             <= next_nsp_seen;
            interrupt_flag       <= next_int_flag;
            extension_flag       <= next_ext_flag;
            r_data               <= next_r_data;
            r_port_func          <= next_r_func;
            p_dir                <= next_p_dir;
            p_port_out           <= next_p_data;
            p_port_func          <= next_p_func;
        end
    end

    assign int_enable  = wsp_seen & nsp_seen & ~init_reset;
    assign r_port_out  = r_data;
    assign p_port_oe_n = ~p_dir;
    assign p_pullup_en = ~p_dir & P_PULLUP;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Worst case: tick just went low, half a divider period to wait
    localparam int           HOLD_MAX     = 1 << (DIV_W - 1);
    localparam logic [DIV_W:0] HOLD_MAX_CNT = HOLD_MAX[DIV_W:0];
    logic [DIV_W:0] hold_ticks;

    always_ff @(posedge mclk) begin
        if (!rst_n || !init_reset || !pin_s || key_req) begin
            hold_ticks <= '0;
        end else if (osc_rise) begin
            hold_ticks <= hold_ticks + {{DIV_W{1'b0}}, 1'b1};
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_pin_sets_reset: assert property (!pin_s |=> init_reset)
        else $error("pin low did not assert reset");
    chk_latch_holds: assert property (
        init_reset && !tick_high |=> init_reset)
        else $error("reset released without tick");
    chk_release_cause: assert property (
        $fell(init_reset) |-> $past(tick_high) && $past(pin_s))
        else $error("reset released without tick and pin high");
    chk_release_bound: assert property (
        hold_ticks <= HOLD_MAX_CNT)
        else $error("reset release took too long");
    chk_key_sets_reset: assert property (
        key_req |=> init_reset)
        else $error("key request did not assert reset");
    chk_flags_cleared: assert property (
        init_reset |=> !interrupt_flag && !extension_flag
                       && pc_start == PC_RESET)
        else $error("core flags not cleared in reset");
    chk_int_pairing: assert property (
        int_enable |-> wsp_seen && nsp_seen && !init_reset)
        else $error("interrupts enabled without both pointers");
    chk_prefix_ext: assert property (
        wr_acc && paddr == OFS_PREFIX |=> extension_flag)
        else $error("prefix write did not set extension flag");
    chk_port_reset: assert property (
        init_reset |=> r_port_out == R_DATA_RST && p_port_oe_n == '1
            && r_port_func == '0 && p_port_func == '0)
        else $error("ports not in reset state");
    chk_div_runs: assert property (
        init_reset && osc_rise |=> div != $past(div))
        else $error("divider stalled in reset");

    cov_pin_release: cover property ($fell(init_reset));
    cov_key_reset: cover property (key_req ##1 init_reset);
    cov_int_enable: cover property ($rose(int_enable));
    cov_prefix: cover property (wr_acc && paddr == OFS_PREFIX);

endmodule // irc_controller

// ===== bench/irc_board.sv
// Board model: external reset source and key switches
`timescale 1ns/1ns
module irc_board #(
    parameter int PIN_MIN = 8
) (
    input  wire logic       mclk,
    input  wire logic       pin_req,
    input  wire logic [3:0] key_press,
    output logic            reset_pin_n,
    output logic [3:0]      key_input_ports
);
    int hold = PIN_MIN;
    // Pin starts low at power-up, held PIN_MIN cycles past any request
    initial reset_pin_n = 1'b0;
    always @(posedge mclk) begin
        if (pin_req) begin
            reset_pin_n <= 1'b0;
            hold        <= PIN_MIN;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end else begin
            reset_pin_n <= 1'b1;
        end
    end
    // Keys pulled high, low only when the bench presses them
    assign key_input_ports = ~key_press;
endmodule // irc_board

// ===== bench/testbench.sv
// Self-checking testbench for the initial reset controller
`timescale 1ns/1ns
module testbench
    import irc_pkg::*;
;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d, e; logic r;}
        irc_row_type;
    logic        mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        osc = 0, pin_req = 1, pready, pslverr, pin_n, ini;
    logic        ifl, efl, ien, er;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic [3:0]  keys = 0, kin;
    logic [15:0] pc, p_oe_n, p_pu, p_fn;
    logic [11:0] r_out, r_fn;
    int          errors = 0, checked = 0;
    irc_row_type rows[12] = '{
        '{1, 8'h04, 'h3ff, 0, 0}, '{0, 8'h00, 0, 'h10, 0},
        '{1, 8'h08, 'hff, 0, 0},  '{0, 8'h00, 0, 'h14, 0},
        '{0, 8'h04, 0, 'h3ff, 0}, '{1, 8'h14, 'ha5, 0, 0},
        '{0, 8'h14, 0, 'ha5, 0},  '{1, 8'h10, 1, 0, 0},
        '{0, 8'h10, 0, 1, 0},     '{0, 8'h2c, 0, 0, 1},
        '{1, 8'h0c, 'h12, 0, 0},  '{0, 8'h00, 0, 'h1c, 0}};
    always #10 mclk = ~mclk;
    // Slow oscillator sped up to 40 cycles so releases fit the run
    always #400 osc = ~osc;
    irc_board i_board (.mclk(mclk), .pin_req(pin_req), .key_press(keys),
        .reset_pin_n(pin_n), .key_input_ports(kin));
    irc_controller #(.NOISE_TICKS(4), .AUTH_TICKS(100), .DIV_W(4)) i_dut (
        .mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reset_pin_n(pin_n), .slow_oscillator(osc),
        .key_input_ports(kin), .cpu_step(1'b0), .init_reset(ini),
        .pc_start(pc), .interrupt_flag(ifl), .extension_flag(efl),
        .int_enable(ien), .word_stack_pointer(),
        .nibble_stack_pointer(), .r_port_out(r_out), .r_port_func(r_fn),
        .p_port_in(16'h0000), .p_port_out(), .p_port_oe_n(p_oe_n),
        .p_pullup_en(p_pu), .p_port_func(p_fn));
    task print_verdict;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task chk(input logic [47:0] s, input logic [47:0] x);
        checked++;
        if (s !== x) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, s, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q  = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 50) begin
            errors++;
            print_verdict();
        end
    endtask
    // Bounded wait for the internal reset to reach a level
    task automatic wait_rst(input logic v, input int lim);
        int k = 0;
        while (ini !== v && k < lim) begin
            @(posedge mclk);
            k++;
        end
        chk(ini, v);
        if (ini !== v) print_verdict();
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        chk({ini, pc, ifl, efl, ien}, {1'b1, 16'h0110, 3'b000});
        chk({r_out, r_fn, p_fn}, {12'hfff, 28'h0});
        chk({p_oe_n, p_pu}, 32'hffffffff);
        rst_n   <= 1'b1;
        pin_req <= 1'b0;
        wait_rst(0, 900);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(q & (rows[i].a ? '1 : 'h1f), rows[i].e);
            chk(er, rows[i].r);
        end
        @(posedge mclk) pin_req <= 1'b1;
        @(posedge mclk) pin_req <= 1'b0;
        wait_rst(1, 20);
        repeat (5) @(posedge mclk);
        chk(ini, 1'b1);
        wait_rst(0, 700);
        chk({ifl, efl, ien, r_out}, {3'b000, 12'hfff});
        keys <= 4'b0111;
        repeat (400) @(posedge mclk);
        chk(ini, 1'b0);
        keys <= 4'b1111;
        repeat (100) @(posedge mclk);
        keys <= 4'b0000;
        repeat (200) @(posedge mclk);
        chk(ini, 1'b0);
        keys <= 4'b1111;
        wait_rst(1, 400);
        keys <= 4'b0000;
        wait_rst(0, 900);
        print_verdict();
    end
endmodule // testbench
